// file: core/cip_pkg.sv
// Constants shared by the card IDE host port
`default_nettype none
package cip_pkg;
	localparam int unsigned CIP_CLK_MHZ        = 125;
	// Strobe phases and card reset pulse in nanoseconds; cycle counts derived from the clock rate
	localparam int unsigned CIP_SETUP_NS       = 70;
	localparam int unsigned CIP_STROBE_NS      = 290;
	localparam int unsigned CIP_HOLD_NS        = 30;
	localparam int unsigned CIP_RESET_NS       = 25000;
	localparam int unsigned CIP_SETUP_CYC      = (CIP_SETUP_NS * CIP_CLK_MHZ + 999) / 1000;
	localparam int unsigned CIP_STROBE_CYC     = (CIP_STROBE_NS * CIP_CLK_MHZ + 999) / 1000;
	localparam int unsigned CIP_HOLD_CYC       = (CIP_HOLD_NS * CIP_CLK_MHZ + 999) / 1000;
	localparam int unsigned CIP_RESET_CYC      = (CIP_RESET_NS * CIP_CLK_MHZ + 999) / 1000;
	localparam int unsigned CIP_CNT_W          = 16;
	localparam int unsigned CIP_DATA_W         = 16;
	localparam int unsigned CIP_ADDR_W         = 3;
	localparam logic [15:0] CIP_BYTE_MASK      = 16'h00FF;
	typedef enum logic [1:0] {
		CIP_SEL_TASKFILE,
		CIP_SEL_ALT,
		CIP_SEL_DATA
	} cip_sel_t;
endpackage
`default_nettype wire

// file: core/cip_pin_sync.sv
// Three-stage synchroniser for card inputs; value updates when stages two and three agree
`default_nettype none
module cip_pin_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin_in,
	output var  logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= RST_VAL;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					pin_out[i] <= s3_ff[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: core/cip_host_port.sv
// Card IDE host port: strobe sequencer, pin drive and card status inputs
// Contract
// - Drive an active-low alternate-register chip select toward the card.
// - Drive the active-low task-file chip select low for every task-file access.
// - Present a three-bit register address on bits 2..0 for every access.
// - A high card interrupt input means a card interrupt is pending.
// - Register accesses use data lines 7..0 only; data-block transfers use all 16 lines.
// - A high io-ready input means the card may complete the current access.
// - The card counts as present only when both detect inputs are low.
// - Drive an active-low card reset that holds the card in reset while low.
// - Pulse the active-low read strobe only while the controller is enabled.
// - Pulse the active-low write strobe only while the controller is enabled.
`default_nettype none
module cip_host_port
	import cip_pkg::*;
#(
	parameter int unsigned SETUP_CYC  = CIP_SETUP_CYC,
	parameter int unsigned STROBE_CYC = CIP_STROBE_CYC,
	parameter int unsigned HOLD_CYC   = CIP_HOLD_CYC,
	parameter int unsigned RESET_CYC  = CIP_RESET_CYC
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	input  wire logic                  ctrl_enable,
	input  wire logic                  card_reset_req,
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire logic                  req_write,
	input  wire cip_sel_t              req_sel,
	input  wire logic [CIP_ADDR_W-1:0] req_addr,
	input  wire logic [CIP_DATA_W-1:0] req_wdata,
	output var  logic                  rsp_valid,
	output var  logic [CIP_DATA_W-1:0] rsp_rdata,
	output var  logic                  card_present,
	output var  logic                  card_irq_pending,
	output var  logic                  card_in_reset,
	output var  logic                  taskfile_select_n,
	output var  logic                  alt_reg_select_n,
	output var  logic                  reg_addr_bit2,
	output var  logic                  reg_addr_bit1,
	output var  logic                  reg_addr_bit0,
	output var  logic                  card_read_strobe_n,
	output var  logic                  card_write_strobe_n,
	output var  logic                  card_reset_out_n,
	input  wire logic [CIP_DATA_W-1:0] card_data_bus_in,
	output var  logic [CIP_DATA_W-1:0] card_data_bus_out,
	output var  logic                  card_data_bus_oe,
	input  wire logic                  card_irq_in,
	input  wire logic                  card_io_ready_in,
	input  wire logic                  card_detect_a_n,
	input  wire logic                  card_detect_b_n
);
	typedef enum logic [2:0] {
		CIP_IDLE,
		CIP_SETUP,
		CIP_STROBE,
		CIP_WAIT_RDY,
		CIP_HOLD
	} cip_state_t;

	localparam logic [CIP_CNT_W-1:0] SETUP_LD  = CIP_CNT_W'(SETUP_CYC - 1);
	localparam logic [CIP_CNT_W-1:0] STROBE_LD = CIP_CNT_W'(STROBE_CYC - 1);
	localparam logic [CIP_CNT_W-1:0] HOLD_LD   = CIP_CNT_W'(HOLD_CYC - 1);
	localparam logic [CIP_CNT_W-1:0] RESET_LD  = CIP_CNT_W'(RESET_CYC - 1);

	logic                  rst_s1_ff;
	logic                  rst_s2_ff;
	logic                  rst_n;
	logic [3:0]            pins_sync;
	logic                  detect_a_n_s;
	logic                  detect_b_n_s;
	logic                  io_ready_s;
	logic                  irq_s;
	cip_state_t            state_ff;
	cip_state_t            nxt_state;
	logic [CIP_CNT_W-1:0]  cnt_ff;
	logic                  write_ff;
	cip_sel_t              sel_ff;
	logic [CIP_ADDR_W-1:0] addr_ff;
	logic [CIP_DATA_W-1:0] wdata_ff;
	logic [CIP_CNT_W-1:0]  rst_cnt_ff;
	logic                  rst_active_ff;
	logic                  cnt_zero;
	logic                  take;
	logic                  nxt_write;
	cip_sel_t              nxt_sel;
	logic [CIP_ADDR_W-1:0] nxt_addr;
	logic [CIP_DATA_W-1:0] nxt_wdata;

	// Register accesses carry one byte, data-block accesses the whole word
	function automatic logic [CIP_DATA_W-1:0] cip_lane_mask(input cip_sel_t sel,
		input logic [CIP_DATA_W-1:0] data);
		return (sel == CIP_SEL_DATA) ? data : (data & CIP_BYTE_MASK);
	endfunction

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	assign rst_n = rst_s2_ff;

	// Detect pins idle high (pull-ups), irq idles low
	cip_pin_sync #(
		.WIDTH   (4),
		.RST_VAL (4'hE)
	) u_pin_sync (
		.clk     (core_clk),
		.rst_n   (rst_n),
		.pin_in  ({card_detect_b_n, card_detect_a_n, card_io_ready_in, card_irq_in}),
		.pin_out (pins_sync)
	);
	assign irq_s        = pins_sync[0];
	assign io_ready_s   = pins_sync[1];
	assign detect_a_n_s = pins_sync[2];
	assign detect_b_n_s = pins_sync[3];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			card_present     <= 1'b0;
			card_irq_pending <= 1'b0;
		end else begin
			card_present     <= !detect_a_n_s && !detect_b_n_s;
			card_irq_pending <= irq_s;
		end
	end

	// Card reset pulse; starts asserted after core reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_active_ff <= 1'b1;
			rst_cnt_ff    <= RESET_LD;
		end else if (card_reset_req) begin
			rst_active_ff <= 1'b1;
			rst_cnt_ff    <= RESET_LD;
		end else if (rst_active_ff) begin
			if (rst_cnt_ff == '0) begin
				rst_active_ff <= 1'b0;
			end else begin
				rst_cnt_ff <= rst_cnt_ff - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			card_reset_out_n <= 1'b0;
		end else begin
			card_reset_out_n <= !rst_active_ff;
		end
	end
	assign card_in_reset = rst_active_ff;

	// No access starts while the card is held in reset or the controller is off
	assign req_ready = (state_ff == CIP_IDLE) && ctrl_enable && !rst_active_ff;
	assign take      = req_valid && req_ready;
	assign cnt_zero  = (cnt_ff == '0);

	// Pins follow the new request from the take edge on, so setup never shows the last access
	assign nxt_write = take ? req_write : write_ff;
	assign nxt_sel   = take ? req_sel : sel_ff;
	assign nxt_addr  = take ? req_addr : addr_ff;
	assign nxt_wdata = take ? cip_lane_mask(req_sel, req_wdata) : wdata_ff;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			CIP_IDLE:     if (take) nxt_state = CIP_SETUP;
			CIP_SETUP:    if (cnt_zero) nxt_state = CIP_STROBE;
			CIP_STROBE:   if (cnt_zero) nxt_state = CIP_WAIT_RDY;
			CIP_WAIT_RDY: if (io_ready_s || !ctrl_enable) nxt_state = CIP_HOLD;
			CIP_HOLD:     if (cnt_zero) nxt_state = CIP_IDLE;
			default:      nxt_state = CIP_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= CIP_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (state_ff != nxt_state) begin
			unique case (nxt_state)
				CIP_SETUP:  cnt_ff <= SETUP_LD;
				CIP_STROBE: cnt_ff <= STROBE_LD;
				CIP_HOLD:   cnt_ff <= HOLD_LD;
				default:    cnt_ff <= '0;
			endcase
		end else if (!cnt_zero) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	// Request captured once; stays fixed until the next take
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			write_ff <= 1'b0;
			sel_ff   <= CIP_SEL_TASKFILE;
			addr_ff  <= '0;
			wdata_ff <= '0;
		end else if (take) begin
			write_ff <= nxt_write;
			sel_ff   <= nxt_sel;
			addr_ff  <= nxt_addr;
			wdata_ff <= nxt_wdata;
		end
	end

	// Pin drive registered; selects span setup through hold
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			taskfile_select_n   <= 1'b1;
			alt_reg_select_n    <= 1'b1;
			reg_addr_bit2       <= 1'b0;
			reg_addr_bit1       <= 1'b0;
			reg_addr_bit0       <= 1'b0;
			card_read_strobe_n  <= 1'b1;
			card_write_strobe_n <= 1'b1;
			card_data_bus_out   <= '0;
			card_data_bus_oe    <= 1'b0;
		end else begin
			// Data window uses the task-file select, as an IDE data port does
			taskfile_select_n <= !((nxt_state != CIP_IDLE) && (nxt_sel != CIP_SEL_ALT));
			alt_reg_select_n  <= !((nxt_state != CIP_IDLE) && (nxt_sel == CIP_SEL_ALT));
			reg_addr_bit2     <= nxt_addr[2];
			reg_addr_bit1     <= nxt_addr[1];
			reg_addr_bit0     <= nxt_addr[0];
			card_read_strobe_n <= !(ctrl_enable && !nxt_write &&
				(nxt_state == CIP_STROBE || nxt_state == CIP_WAIT_RDY));
			card_write_strobe_n <= !(ctrl_enable && nxt_write &&
				(nxt_state == CIP_STROBE || nxt_state == CIP_WAIT_RDY));
			card_data_bus_out <= nxt_wdata;
			card_data_bus_oe  <= nxt_write && (nxt_state != CIP_IDLE);
		end
	end

	// Read data sampled as the strobe ends
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			rsp_valid <= (state_ff == CIP_HOLD) && cnt_zero;
			if (state_ff == CIP_WAIT_RDY && nxt_state == CIP_HOLD && !write_ff) begin
				rsp_rdata <= cip_lane_mask(sel_ff, card_data_bus_in);
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/cip_props.sv
// Pin-level checker for the card IDE host port
`default_nettype none
module cip_props (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ctrl_enable,
	input wire logic card_reset_req,
	input wire logic card_present,
	input wire logic card_irq_pending,
	input wire logic taskfile_select_n,
	input wire logic alt_reg_select_n,
	input wire logic reg_addr_bit2,
	input wire logic reg_addr_bit1,
	input wire logic reg_addr_bit0,
	input wire logic card_read_strobe_n,
	input wire logic card_write_strobe_n,
	input wire logic card_reset_out_n,
	input wire logic card_irq_in,
	input wire logic card_io_ready_in,
	input wire logic card_detect_a_n,
	input wire logic card_detect_b_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire logic       strb = !(card_read_strobe_n && card_write_strobe_n);
	wire logic [4:0] pins = {taskfile_select_n, alt_reg_select_n,
		reg_addr_bit2, reg_addr_bit1, reg_addr_bit0};
	sequence s_strobing; strb ##1 strb; endsequence
	sequence s_rdy_low; !card_io_ready_in [*7]; endsequence
	property p_one_sel; !(!taskfile_select_n && !alt_reg_select_n); endproperty
	property p_sel_strb; strb |-> !(taskfile_select_n && alt_reg_select_n); endproperty
	property p_hold; s_strobing |-> $stable(pins); endproperty
	// Strobe pins are registered, so they answer to the enable of the cycle before
	property p_rd_en; !card_read_strobe_n |-> $past(ctrl_enable); endproperty
	property p_wr_en; !card_write_strobe_n |-> $past(ctrl_enable); endproperty
	property p_rst_req; $rose(card_reset_req) |-> ##[1:4] !card_reset_out_n; endproperty
	// Three extra cycles cover the input synchroniser delay
	property p_present;
		(!card_detect_a_n && !card_detect_b_n) [*8] |-> ##3 card_present;
	endproperty
	property p_irq; card_irq_in [*8] |-> ##3 card_irq_pending; endproperty
	property p_io_wait;
		s_rdy_low |-> !$rose(card_read_strobe_n) && !$rose(card_write_strobe_n);
	endproperty
	a_one_sel: assert property (p_one_sel) else $error("two selects low");
	a_sel_strb: assert property (p_sel_strb) else $error("strobe unselected");
	a_hold: assert property (p_hold) else $error("pins moved in strobe");
	a_rd_en: assert property (p_rd_en) else $error("read while off");
	a_wr_en: assert property (p_wr_en) else $error("write while off");
	a_rst_req: assert property (p_rst_req) else $error("no card reset");
	a_present: assert property (p_present) else $error("card not seen");
	a_irq: assert property (p_irq) else $error("irq not seen");
	a_io_wait: assert property (p_io_wait) else $error("strobe ended early");
endmodule
bind cip_host_port cip_props u_props (.*);
`default_nettype wire

// file: verif/cip_card_model.sv
// Behavioural card in IDE mode whose ready line can be held off
`default_nettype none
module cip_card_model (
	input  wire logic        clk,
	input  wire logic        cs0_n,
	input  wire logic        cs1_n,
	input  wire logic [2:0]  addr,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [15:0] bus,
	input  wire logic [7:0]  slow,
	output var  logic        drv,
	output var  logic [15:0] val,
	output var  logic        rdy
);
	logic [15:0]     mem [16] = '{default: 16'h0000};
	logic [7:0]      cnt = 8'h00;
	wire  logic [3:0] idx = {!cs1_n, addr};
	wire  logic       sel = !(cs0_n && cs1_n);
	assign drv = sel && !rd_n;
	// Data is only good once ready is up, so a host that samples early reads junk
	assign val = rdy ? mem[idx] : ~mem[idx];
	assign rdy = cnt >= slow;
	always @(posedge clk) begin
		cnt <= (sel && !(rd_n && wr_n)) ? cnt + 8'h01 : 8'h00;
		// Junk above the low byte of every register but index 0, so a host that passes it on is caught
		if (sel && !wr_n)
			mem[idx] <= (idx == 4'h0) ? bus : {8'hC3, bus[7:0]};
	end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the card IDE host port
`default_nettype none
module tb_top
	import cip_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst_b = 0, ctrl_enable = 1, card_reset_req = 0, req_valid = 0;
	logic req_write = 0, card_irq_in = 0, card_detect_a_n = 0, card_detect_b_n = 0;
	cip_sel_t    req_sel = CIP_SEL_TASKFILE;
	logic [2:0]  req_addr = 3'h0;
	logic [15:0] req_wdata = 16'h0000, rsp_rdata, card_data_bus_in, card_data_bus_out, val;
	logic        req_ready, rsp_valid, card_present, card_irq_pending, card_in_reset, drv;
	logic        taskfile_select_n, alt_reg_select_n, reg_addr_bit2, reg_addr_bit1;
	logic        reg_addr_bit0, card_read_strobe_n, card_write_strobe_n, card_reset_out_n;
	logic        card_data_bus_oe, card_io_ready_in;
	logic [7:0]  slow = 8'h00;
	int          error_cnt = 0, checks = 0, seed = 32'hAD55A8F1;
	int          ref_mem [16] = '{default: 0};
	cip_host_port #(.SETUP_CYC(1), .STROBE_CYC(2), .HOLD_CYC(1), .RESET_CYC(8)) uut (.*);
	cip_card_model card (.clk(core_clk), .cs0_n(taskfile_select_n), .cs1_n(alt_reg_select_n),
		.addr({reg_addr_bit2, reg_addr_bit1, reg_addr_bit0}), .rd_n(card_read_strobe_n),
		.wr_n(card_write_strobe_n), .bus(card_data_bus_in), .slow(slow), .drv(drv),
		.val(val), .rdy(card_io_ready_in));
	// Weak pull-down pulls a released bus to zero
	assign card_data_bus_in = card_data_bus_oe ? card_data_bus_out : (drv ? val : 16'h0000);
	initial forever #4 core_clk = !core_clk;
	task automatic chk_w(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp, input string what);
		chk_w({15'h0000, got}, {15'h0000, exp}, what);
	endtask
	task automatic wait_rdy;
		int n = 0;
		while (req_ready !== 1'h1 && n++ < 200) @(negedge core_clk);
		if (n > 200) chk_b(1'h0, 1'h1, "no ready");
	endtask
	task automatic xfer(input logic w, input cip_sel_t s, input logic [2:0] a,
		input logic [15:0] d);
		int i;
		int n = 0;
		i = {s == CIP_SEL_ALT, a};
		{req_valid, req_write, req_addr, req_wdata} = {1'h1, w, a, d};
		req_sel = s;
		wait_rdy;
		@(negedge core_clk);
		req_valid = 1'h0;
		while (rsp_valid !== 1'h1 && n++ < 200) @(negedge core_clk);
		if (n > 200) chk_b(1'h0, 1'h1, "no response");
		if (w) ref_mem[i] = (s == CIP_SEL_DATA) ? d : d & 16'h00FF;
		else chk_w(rsp_rdata, 16'(s == CIP_SEL_DATA ? ref_mem[i] : ref_mem[i] & 255), "rd");
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#(5000 * 8);
		error_cnt++;
		final_report;
	end
	initial begin
		logic [15:0] d;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk) rst_b = 1'h1;
		chk_b(card_reset_out_n, 1'h0, "reset out");
		chk_b(card_in_reset, 1'h1, "in reset");
		wait_rdy;
		chk_b(card_in_reset, 1'h0, "reset over");
		// The reset pin follows the pulse flop one cycle later
		@(negedge core_clk);
		chk_b(card_reset_out_n, 1'h1, "reset end");
		$display("test reset done");
		for (int k = 0; k < 16; k++) begin
			d = 16'($random(seed));
			xfer(1'h1, k[3] ? CIP_SEL_ALT : CIP_SEL_TASKFILE, k[2:0], d);
			xfer(1'h0, k[3] ? CIP_SEL_ALT : CIP_SEL_TASKFILE, k[2:0], d);
		end
		$display("test regs done");
		slow = 8'h0C;
		// Let the synchronised ready line settle low before the first slow access
		repeat (4) @(negedge core_clk);
		repeat (3) begin
			d = 16'($random(seed));
			xfer(1'h1, CIP_SEL_DATA, 3'h0, d);
			xfer(1'h0, CIP_SEL_DATA, 3'h0, d);
		end
		slow = 8'h00;
		$display("test data done");
		ctrl_enable = 1'h0;
		req_valid = 1'h1;
		repeat (6) @(negedge core_clk);
		chk_b(req_ready, 1'h0, "ready off");
		chk_b(card_write_strobe_n && card_read_strobe_n, 1'h1, "strobe off");
		{req_valid, ctrl_enable} = 2'h1;
		$display("test enable done");
		for (int k = 3; k >= 0; k--) begin
			{card_detect_a_n, card_detect_b_n, card_irq_in} = {k[1:0], k[0]};
			repeat (12) @(negedge core_clk);
			chk_b(card_present, k == 0, "present");
			chk_b(card_irq_pending, k[0], "irq");
		end
		$display("test pins done");
		card_reset_req = 1'h1;
		@(negedge core_clk) card_reset_req = 1'h0;
		repeat (2) @(negedge core_clk);
		chk_b(card_reset_out_n, 1'h0, "card reset");
		chk_b(req_ready, 1'h0, "ready in reset");
		chk_b(card_in_reset, 1'h1, "in card reset");
		xfer(1'h0, CIP_SEL_ALT, 3'h6, 16'h0000);
		$display("test card reset done");
		final_report;
	end
endmodule
`default_nettype wire
